// file: common/host_port_pkg.sv
// Summary of operation
// - while reset is low, every host access is ignored
// - while reset is low, panel data, line pulse and polarity halt
// - direct mode: writing bit 0 at offset 08h leaves power save
// - indirect mode: system init command leaves power save
// - falling read or write strobe drives wait low
// - after strobe rises, wait returns to high impedance
// - wait active no longer than four system clocks plus 2 ns; here wait is held seven to eight system clocks from strobe fall
// - read data valid within one system clock after wait release
// - read data driven only after read strobe falls, freed on select rise; here freed on read strobe rise or select rise, whichever comes first
package host_port_pkg;
  localparam int unsigned CLK_MHZ = 25;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // wait limit four system clocks; access releases wait seven to eight clocks after strobe fall
  localparam int unsigned WAIT_MAX_TS = 4;
  localparam logic [2:0] WAIT_MAX_CYC = 3'(WAIT_MAX_TS);
  localparam logic [2:0] ACCESS_CYC = 3'h3;
  localparam logic [ADDR_W-1:0] PWR_REG_OFS = 16'h0008;
  localparam int unsigned PWR_BIT = 0;
  localparam logic [DATA_W-1:0] SYS_INIT_CMD = 8'h40;
  localparam logic [DATA_W-1:0] REG_RESET_VAL = 8'h00;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } host_bus_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic data_oe;
    logic wait_n;
    logic wait_oe;
  } host_resp_t;
endpackage : host_port_pkg

// file: design/host_bus_port.sv
`timescale 1ns/100ps
module host_bus_port
  import host_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire host_bus_t bus_in,
  input wire logic indirect_mode_in,
  input wire logic [DATA_W-1:0] rd_data_in,
  input wire logic panel_run_in,
  output host_resp_t resp_out,
  output logic wr_stb_out,
  output logic rd_stb_out,
  output logic [ADDR_W-1:0] acc_addr_out,
  output logic [DATA_W-1:0] acc_data_out,
  output logic power_save_out,
  output logic osc_start_out,
  output logic panel_enable_out
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_BUSY = 4'h2,
    ST_DONE = 4'h4,
    ST_HOLD = 4'h8
  } acc_state_t;

  function automatic logic is_wake(input logic ind, input logic [ADDR_W-1:0] a,
                                   input logic [DATA_W-1:0] d);
    is_wake = ind ? (d == SYS_INIT_CMD) : (a == PWR_REG_OFS && d[PWR_BIT]);
  endfunction : is_wake

  logic rst_s1_r, rst_s2_r;
  // reset released through two flops, asserted at once
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  // three-stage pin synchronisers; only stages two and three are read
  logic [2:0] cs_sy_r, rd_sy_r, wr_sy_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdat_r;
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_sy_r <= 3'h7;
      rd_sy_r <= 3'h7;
      wr_sy_r <= 3'h7;
    end
    else
    begin
      cs_sy_r <= {cs_sy_r[1:0], bus_in.cs_n};
      rd_sy_r <= {rd_sy_r[1:0], bus_in.rd_n};
      wr_sy_r <= {wr_sy_r[1:0], bus_in.wr_n};
    end
  end
  // address and data are stable while a strobe is low, sampled late
  always_ff @(posedge clk_sys_in)
  begin
    addr_r <= bus_in.addr;
    wdat_r <= bus_in.data;
  end

  logic cs_lo, rd_lo, wr_lo, rd_hi, wr_hi;
  always_comb
  begin
    cs_lo = (cs_sy_r[2:1] == 2'h0);
    rd_lo = (rd_sy_r[2:1] == 2'h0);
    wr_lo = (wr_sy_r[2:1] == 2'h0);
    rd_hi = (rd_sy_r[2:1] == 2'h3);
    wr_hi = (wr_sy_r[2:1] == 2'h3);
  end

  acc_state_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic is_rd_r, is_rd_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic pws_r, pws_nxt;
  logic wr_stb, rd_stb;

  // access sequencer: stall, do access, release wait, await strobe rise
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    is_rd_nxt = is_rd_r;
    dout_nxt = dout_r;
    pws_nxt = pws_r;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    case (st_r)
      ST_IDLE:
      begin
        if (cs_lo && (rd_lo || wr_lo))
        begin
          st_nxt = ST_BUSY;
          is_rd_nxt = rd_lo;
          cnt_nxt = 3'h1;
        end
      end
      ST_BUSY:
      begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r >= ACCESS_CYC)
        begin
          st_nxt = ST_DONE;
          rd_stb = is_rd_r;
          wr_stb = !is_rd_r;
          if (!is_rd_r && is_wake(indirect_mode_in, addr_r, wdat_r))
            pws_nxt = 1'b0;
        end
      end
      ST_DONE:
      begin
        if (is_rd_r)
          dout_nxt = rd_data_in;
        st_nxt = ST_HOLD;
      end
      ST_HOLD:
      begin
        if ((is_rd_r && rd_hi) || (!is_rd_r && wr_hi))
          st_nxt = ST_IDLE;
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 3'h0;
      is_rd_r <= 1'b0;
      dout_r <= REG_RESET_VAL;
      pws_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      is_rd_r <= is_rd_nxt;
      dout_r <= dout_nxt;
      pws_r <= pws_nxt;
    end
  end

  // wait low from strobe fall, then floated, never driven high
  always_comb
  begin
    resp_out.wait_n = 1'b0;
    resp_out.wait_oe = rst_n && !bus_in.cs_n && (!bus_in.rd_n || !bus_in.wr_n)
                       && (st_r != ST_HOLD);
    // data driven only in read with strobe low and select low
    resp_out.data_oe = rst_n && !bus_in.cs_n && !bus_in.rd_n && is_rd_r
                       && (st_r == ST_HOLD);
    resp_out.data = dout_r;
  end

  assign panel_enable_out = rst_n && panel_run_in && !pws_r;
  assign wr_stb_out = wr_stb;
  assign rd_stb_out = rd_stb;
  assign acc_addr_out = addr_r;
  assign acc_data_out = wdat_r;
  assign power_save_out = pws_r;
  assign osc_start_out = !pws_r;

  a_wait_bounded: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_r == ST_BUSY) |-> ##[1:5] (st_r == ST_DONE))
    else $error("wait held too long");
  a_access_one: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (wr_stb || rd_stb) |=> !(wr_stb || rd_stb))
    else $error("double access pulse");
  a_wake_clears: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (wr_stb && is_wake(indirect_mode_in, addr_r, wdat_r)) |=> !pws_r)
    else $error("power save not left");
  a_wait_released: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_r == ST_HOLD) |-> !resp_out.wait_oe)
    else $error("wait driven after access");
  a_data_valid: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (st_r == ST_DONE && is_rd_r) |=> (dout_r == $past(rd_data_in)))
    else $error("read data not captured");
  a_data_gated: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    resp_out.data_oe |-> !bus_in.rd_n && !bus_in.cs_n)
    else $error("data driven outside read");
  a_panel_halt: assert property (@(posedge clk_sys_in)
    !rst_n |-> !panel_enable_out)
    else $error("panel running in reset");
  a_reset_ignore: assert property (@(posedge clk_sys_in)
    !rst_n |-> !wr_stb && !rd_stb)
    else $error("access taken in reset");
endmodule : host_bus_port

// file: tb/host_cpu_model.sv
`timescale 1ns/100ps
// host processor on the asynchronous parallel bus
module host_cpu_model
  import host_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire host_resp_t resp_in,
  output host_bus_t bus_out,
  output logic [7:0] wait_cyc_out
);
  initial
  begin
    bus_out = '{1'b1, 1'b1, 1'b1, 16'h0000, 8'hFF};
    wait_cyc_out = 8'h00;
  end
  // one byte access; strobe held until wait drops
  task automatic cycle(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
    @(negedge clk_sys_in);
    bus_out.cs_n = 1'b0;
    bus_out.addr = a;
    // data set well before strobe rise
    bus_out.data = d;
    @(negedge clk_sys_in);
    bus_out.rd_n = wr;
    bus_out.wr_n = !wr;
    wait_cyc_out = 8'h00;
    // wait sampled on falling edges, clear of the sequencer's own edge
    @(negedge clk_sys_in);
    while (resp_in.wait_oe && wait_cyc_out < 8'h20)
    begin
      wait_cyc_out++;
      @(negedge clk_sys_in);
    end
    // read data taken at the edge that sees wait released
    q = resp_in.data;
    @(negedge clk_sys_in);
    bus_out.rd_n = 1'b1;
    bus_out.wr_n = 1'b1;
    @(negedge clk_sys_in);
    bus_out.cs_n = 1'b1;
    // released bus has no pull, so show a changed value
    bus_out.data = ~d;
    // idle gap covers write to read
    repeat (6) @(negedge clk_sys_in);
  endtask : cycle
endmodule : host_cpu_model

// file: tb/test_host_bus_wait_reset_sequencing.sv
`timescale 1ns/100ps
module test_host_bus_wait_reset_sequencing
  import host_port_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic indirect_mode_in = 1'b0;
  logic panel_run_in = 1'b1;
  logic [DATA_W-1:0] rd_data_in = 8'h00;
  host_bus_t bus_in;
  host_resp_t resp_out;
  logic wr_stb_out, rd_stb_out, power_save_out, osc_start_out, panel_enable_out;
  logic [ADDR_W-1:0] acc_addr_out;
  logic [DATA_W-1:0] acc_data_out, q;
  logic [7:0] wait_cyc;
  logic [24:0] notes[$];
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 44892;
  host_bus_port i_dut (.clk_sys_in, .rst_n_in, .bus_in, .indirect_mode_in,
    .rd_data_in, .panel_run_in, .resp_out, .wr_stb_out, .rd_stb_out,
    .acc_addr_out, .acc_data_out, .power_save_out, .osc_start_out,
    .panel_enable_out);
  host_cpu_model i_host (.clk_sys_in, .resp_in(resp_out), .bus_out(bus_in),
    .wait_cyc_out(wait_cyc));
  initial
  begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // each internal access pulse is matched to the oldest note
  // sampled at the falling edge, where the pulses are settled
  always @(negedge clk_sys_in)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      miscompares++;
      end_sim();
    end
    else if (wr_stb_out || rd_stb_out)
      if (notes.size() == 0)
        check("stray access", {wr_stb_out, rd_stb_out}, 0);
      else
        check("access", {wr_stb_out, acc_addr_out, wr_stb_out ? acc_data_out : 8'h00},
          notes.pop_front());
  end
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
    input logic live);
    logic [7:0] rd;
    rd = $random(seed);
    @(negedge clk_sys_in);
    rd_data_in = rd;
    if (live)
      notes.push_back({wr, a, wr ? d : 8'h00});
    i_host.cycle(wr, a, d, q);
    if (live)
    begin
      check("wait length", wait_cyc >= 1 && wait_cyc <= 8, 1);
      if (!wr)
        check("read data", q, rd);
    end
    check("wait released", resp_out.wait_oe, 0);
    check("data released", resp_out.data_oe, 0);
  endtask : acc
  // reset pulse, scaled down to 12 clocks
  // panel supply sequencing lies outside this block
  task automatic reset_for_12;
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    check("panel in reset", panel_enable_out, 0);
    check("power save in reset", power_save_out, 1);
    rst_n_in = 1'b1;
    // short settle, then init access at once
    repeat (4) @(negedge clk_sys_in);
  endtask : reset_for_12
  // main sequence: ignored access, wake, random traffic, indirect wake
  initial
  begin
    acc(1'b1, PWR_REG_OFS, 8'h01, 1'b0);
    reset_for_12();
    acc(1'b1, PWR_REG_OFS, 8'h01, 1'b1);
    check("wake direct", {power_save_out, osc_start_out}, 2'b01);
    check("panel running", panel_enable_out, 1);
    // idle gap of the model covers oscillator settle
    repeat (20)
      acc($random(seed), $random(seed) | 16'h0100, $random(seed), 1'b1);
    indirect_mode_in = 1'b1;
    reset_for_12();
    acc(1'b1, 16'h0001, SYS_INIT_CMD, 1'b1);
    check("wake indirect", power_save_out, 0);
    end_sim();
  end
endmodule : test_host_bus_wait_reset_sequencing
